// ==== core/tevm_edge_sync.sv ====
/*
  Two-flop synchroniser for the timer input pin with edge detection.
  Assumes the pin is asynchronous to aclk.
*/
`default_nettype none

module tevm_edge_sync
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and results
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic sync;
  logic prev;

  // ==========================================================
  // synchronise then keep one older sample
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // edges seen between synchronised samples
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule

`default_nettype wire

// ==== core/tevm_pkg.sv ====
/*
  Constants shared by the event, window and pulse-measure timer core:
  register offsets, control field positions, mode codes and timing.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package tevm_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] tevm_ctrl_off = 8'h00;
  localparam logic [7:0] tevm_cmp_off = 8'h04;
  localparam logic [7:0] tevm_cap_off = 8'h08;
  localparam logic [7:0] tevm_caplo_off = 8'h0C;
  localparam logic [7:0] tevm_caphi_off = 8'h10;
  localparam logic [7:0] tevm_cnt_off = 8'h14;
  localparam logic [7:0] tevm_stat_off = 8'h18;

  // ==========================================================
  // control register fields
  localparam int tevm_run_bit = 0;
  localparam int tevm_mode_lsb = 1;
  localparam int tevm_mode_w = 2;
  localparam int tevm_edge_bit = 3;
  localparam int tevm_acap_bit = 4;
  localparam int tevm_mcap_bit = 5;
  localparam int tevm_pol_bit = 6;
  localparam int tevm_div_lsb = 8;
  localparam int tevm_div_w = 8;
  localparam int tevm_ctrl_w = 16;
  localparam logic [15:0] tevm_ctrl_rst = 16'h0000;
  localparam logic [15:0] tevm_cmp_rst = 16'hFFFF;

  // mode field codes
  localparam logic [1:0] tevm_mode_event = 2'h0;
  localparam logic [1:0] tevm_mode_window = 2'h1;
  localparam logic [1:0] tevm_mode_pulse = 2'h2;

  // ==========================================================
  // bus answers
  localparam logic [1:0] tevm_resp_okay = 2'h0;
  localparam logic [1:0] tevm_resp_slverr = 2'h2;

  // ==========================================================
  // timing: interrupt pulse length
  localparam int tevm_clk_mhz = 250;
  localparam int tevm_irq_ns = 8;
  localparam int tevm_irq_cyc = (tevm_irq_ns * tevm_clk_mhz + 999) / 1000;

  typedef enum logic [1:0] {tevm_pw_idle, tevm_pw_high, tevm_pw_low} tevm_pw_t;

endpackage

`default_nettype wire

// ==== core/tevm_timer.sv ====
/*
  16-bit up-counting timer with event count, window gate and pulse
  width or period measure modes, registers over AXI4-Lite.
  Assumes a 250 MHz aclk, a synchronous active-low reset and a pin
  input that holds each level long enough to be sampled.
*/
// The register offsets and the AXI4-Lite register port were left to the implementer.
`default_nettype none

module tevm_timer
  import tevm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer pin and interrupt
  input wire logic timer_input_pin,
  output logic timer_interrupt
);

  logic [15:0] timer_control_reg;
  logic [15:0] compare_period_reg;
  logic [15:0] capture_reg;
  logic [15:0] count;
  logic [7:0] div_cnt;
  logic tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic trig_edge;
  logic opp_edge;
  logic match_pending;
  logic [1:0] irq_cnt;
  logic fire;
  tevm_pw_t pw_state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_rdata;
  logic next_rerr;

  logic run;
  logic [1:0] mode;
  logic edge_fall;
  logic acap;
  logic mcap;
  logic pol_low;
  logic [7:0] div;

  assign run = timer_control_reg[tevm_run_bit];
  assign mode = timer_control_reg[tevm_mode_lsb +: tevm_mode_w];
  assign edge_fall = timer_control_reg[tevm_edge_bit];
  assign acap = timer_control_reg[tevm_acap_bit];
  assign mcap = timer_control_reg[tevm_mcap_bit];
  assign pol_low = timer_control_reg[tevm_pol_bit];
  assign div = timer_control_reg[tevm_div_lsb +: tevm_div_w];

  // ==========================================================
  // pin synchroniser and edge detection
  tevm_edge_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(timer_input_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // selected edge and its opposite
  assign trig_edge = edge_fall ? pin_fall : pin_rise;
  assign opp_edge = edge_fall ? pin_rise : pin_fall;

  // ==========================================================
  // internal source clock: one tick every div+1 aclk cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      div_cnt <= 8'h00;
    else if (div_cnt >= div)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  assign tick = run && (div_cnt >= div);

  // ==========================================================
  // counter, capture and interrupt events per mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 16'h0000;
      capture_reg <= 16'h0000;
      match_pending <= 1'b0;
      pw_state <= tevm_pw_idle;
      fire <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (!run)
      begin
        count <= 16'h0000;
        match_pending <= 1'b0;
        pw_state <= tevm_pw_idle;
      end
      else
      begin
        case (mode)
          tevm_mode_event:
          begin
            if (trig_edge)
              count <= count + 16'h0001;
            if (trig_edge && (count + 16'h0001) == compare_period_reg)
              match_pending <= 1'b1;
            if (opp_edge && match_pending)
            begin
              fire <= 1'b1;
              count <= 16'h0000;
              match_pending <= 1'b0;
            end
            if (tick && acap)
              capture_reg <= count;
          end
          tevm_mode_window:
          begin
            if (tick && (pin_level ^ pol_low))
            begin
              if (count + 16'h0001 == compare_period_reg)
              begin
                fire <= 1'b1;
                count <= 16'h0000;
              end
              else
                count <= count + 16'h0001;
            end
            if (tick && acap)
              capture_reg <= count;
          end
          tevm_mode_pulse:
          begin
            case (pw_state)
              tevm_pw_idle:
              begin
                if (trig_edge)
                  pw_state <= tevm_pw_high;
              end
              tevm_pw_high:
              begin
                if (opp_edge)
                begin
                  capture_reg <= count;
                  fire <= 1'b1;
                  if (mcap)
                  begin
                    count <= 16'h0001;
                    pw_state <= tevm_pw_idle;
                  end
                  else
                  begin
                    // double edge keeps counting through the capture edge
                    pw_state <= tevm_pw_low;
                    if (tick)
                      count <= count + 16'h0001;
                  end
                end
                else if (tick)
                  count <= count + 16'h0001;
              end
              tevm_pw_low:
              begin
                if (trig_edge)
                begin
                  capture_reg <= count;
                  fire <= 1'b1;
                  count <= 16'h0000;
                  pw_state <= tevm_pw_high;
                end
                else if (tick)
                  count <= count + 16'h0001;
              end
              default:
                pw_state <= tevm_pw_idle;
            endcase
          end
          default:
            count <= count;
        endcase
      end
    end
  end

  // ==========================================================
  // interrupt output stretched to a fixed pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_cnt <= 2'h0;
      timer_interrupt <= 1'b0;
    end
    else if (fire)
    begin
      irq_cnt <= 2'(tevm_irq_cyc - 1);
      timer_interrupt <= 1'b1;
    end
    else if (irq_cnt != 2'h0)
      irq_cnt <= irq_cnt - 2'h1;
    else
      timer_interrupt <= 1'b0;
  end

  // ==========================================================
  // write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // register writes and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control_reg <= tevm_ctrl_rst;
      compare_period_reg <= tevm_cmp_rst;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tevm_resp_okay;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= tevm_resp_okay;
      if (aw_addr[7:2] == tevm_ctrl_off[7:2])
      begin
        if (w_strb[0])
          timer_control_reg[7:0] <= w_data[7:0];
        if (w_strb[1])
          timer_control_reg[15:8] <= w_data[15:8];
      end
      else if (aw_addr[7:2] == tevm_cmp_off[7:2])
      begin
        if (w_strb[0])
          compare_period_reg[7:0] <= w_data[7:0];
        if (w_strb[1])
          compare_period_reg[15:8] <= w_data[15:8];
      end
      else if (aw_addr[7:2] > tevm_stat_off[7:2])
        s_axi_bresp <= tevm_resp_slverr;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // read decode
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    if (s_axi_araddr[7:2] == tevm_ctrl_off[7:2])
      next_rdata = {16'h0000, timer_control_reg};
    else if (s_axi_araddr[7:2] == tevm_cmp_off[7:2])
      next_rdata = {16'h0000, compare_period_reg};
    else if (s_axi_araddr[7:2] == tevm_cap_off[7:2])
      next_rdata = {16'h0000, capture_reg};
    else if (s_axi_araddr[7:2] == tevm_caplo_off[7:2])
      next_rdata = {24'h000000, capture_reg[7:0]};
    else if (s_axi_araddr[7:2] == tevm_caphi_off[7:2])
      next_rdata = {24'h000000, capture_reg[15:8]};
    else if (s_axi_araddr[7:2] == tevm_cnt_off[7:2])
      next_rdata = {16'h0000, count};
    else if (s_axi_araddr[7:2] == tevm_stat_off[7:2])
      next_rdata = {28'h0000000, pin_level, match_pending, pw_state};
    else
      next_rerr = 1'b1;
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tevm_resp_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? tevm_resp_slverr : tevm_resp_okay;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== tb/tevm_properties.sv ====
/*
  Port checks for the timer core: bus answers and interrupt pulse.
  Assumes it is bound into tevm_timer and sees only its ports.
*/
`default_nettype none

module tevm_properties
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic timer_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // steps of a transfer
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  irq_pulse_len_a:
    assert property ($rose(timer_interrupt) |=> timer_interrupt ##1 !timer_interrupt)
    else $error("interrupt pulse length wrong");
  write_answer_a:
    assert property (wr_taken_s |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  write_refused_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  write_release_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held too long");
  ready_return_a:
    assert property (s_axi_bvalid && s_axi_bready |-> ##[1:3] (s_axi_awready && s_axi_wready))
    else $error("write readies not back");
  read_answer_a:
    assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("read answer late");
  read_refused_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  read_release_a:
    assert property (rd_taken_s ##1 (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read answer held too long");
  upper_bits_zero_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule

bind tevm_timer tevm_properties u_tevm_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_interrupt(timer_interrupt));

`default_nettype wire

// ==== tb/tevm_pulse_src.sv ====
/*
  Behavioural pulse source on the timer input pin.
  Assumes the caller steps it just after a rising edge of aclk.
*/
`default_nettype none

module tevm_pulse_src
(
  // clock
  input wire logic aclk,
  // driven pin
  output var logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin = 1'b0;

  // hold one level, never shorter than eight clock periods
  task automatic drive(input logic lvl, input int cyc);
    pin <= lvl;
    repeat ((cyc < 8) ? 8 : cyc) @(posedge aclk);
  endtask
endmodule

`default_nettype wire

// ==== tb/tevm_timer_tb.sv ====
/*
  Self-checking bench for the timer core over its register bus.
  Assumes the pulse source model and the bound port checker.
*/
`default_nettype none

module tevm_timer_tb
  import tevm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin, irq, irq_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat, c0, c1;
  logic [1:0] bresp, rresp, resp;
  int errors, samples_checked, irqs, i0;

  tevm_timer u_tevm_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_input_pin(pin), .timer_interrupt(irq));
  tevm_pulse_src u_tevm_pulse_src (.aclk(aclk), .pin(pin));

  // clock and interrupt counting
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    irq_q <= irq;
    if (irq && !irq_q) irqs++;
  end

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rd(a);
    chk(nm, exp, rdat);
  endtask
  // one level on the pin with a capture read in its middle
  task automatic mid(input logic lvl, input int n);
    fork
      u_tevm_pulse_src.drive(lvl, n);
      begin
        repeat (10) @(posedge aclk);
        rd(tevm_cap_off);
      end
    join
  endtask
  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped places
    rchk(tevm_ctrl_off, 32'h0, "control reset");
    chk("mapped read resp", 32'(tevm_resp_okay), 32'(resp));
    rchk(tevm_cmp_off, 32'hFFFF, "compare reset");
    rchk(8'h1C, 32'h0, "unmapped data");
    chk("unmapped read resp", 32'(tevm_resp_slverr), 32'(resp));
    wr(8'h20, 32'h5);
    chk("unmapped write resp", 32'(tevm_resp_slverr), 32'(resp));
    // event counting on rising edges
    wr(tevm_cmp_off, 32'h3);
    chk("mapped write resp", 32'(tevm_resp_okay), 32'(resp));
    wr(tevm_ctrl_off, 32'h1);
    repeat (2) u_tevm_pulse_src.drive(1'b1, 10);
    rchk(tevm_cnt_off, 32'h1, "event count");
    u_tevm_pulse_src.drive(1'b0, 10);
    u_tevm_pulse_src.drive(1'b1, 10);
    rchk(tevm_cnt_off, 32'h2, "event count");
    u_tevm_pulse_src.drive(1'b0, 10);
    i0 = irqs;
    u_tevm_pulse_src.drive(1'b1, 10);
    chk("irq before opposite edge", 32'(i0), 32'(irqs));
    u_tevm_pulse_src.drive(1'b0, 10);
    chk("irq on opposite edge", 32'(i0 + 1), 32'(irqs));
    rchk(tevm_cnt_off, 32'h0, "count cleared");
    u_tevm_pulse_src.drive(1'b1, 10);
    rchk(tevm_cnt_off, 32'h1, "count resumes");
    // falling edge select, then auto capture
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_ctrl_off, 32'h9);
    u_tevm_pulse_src.drive(1'b0, 10);
    rchk(tevm_cnt_off, 32'h1, "falling count");
    u_tevm_pulse_src.drive(1'b1, 10);
    rchk(tevm_cnt_off, 32'h1, "rise ignored");
    wr(tevm_ctrl_off, 32'h19);
    u_tevm_pulse_src.drive(1'b0, 10);
    rchk(tevm_cnt_off, 32'h2, "event count");
    rchk(tevm_cap_off, 32'h2, "auto capture");
    // window gate, both polarities, then match
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_cmp_off, 32'hFFFF);
    wr(tevm_ctrl_off, 32'h3);
    u_tevm_pulse_src.drive(1'b1, 40);
    u_tevm_pulse_src.drive(1'b0, 10);
    rchk(tevm_cnt_off, 32'd40, "window high count");
    // divider of one: a source tick every second clock
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_ctrl_off, 32'h103);
    u_tevm_pulse_src.drive(1'b1, 40);
    u_tevm_pulse_src.drive(1'b0, 10);
    rchk(tevm_cnt_off, 32'd20, "divided window count");
    wr(tevm_ctrl_off, 32'h0);
    u_tevm_pulse_src.drive(1'b1, 10);
    wr(tevm_ctrl_off, 32'h43);
    u_tevm_pulse_src.drive(1'b0, 30);
    u_tevm_pulse_src.drive(1'b1, 10);
    rchk(tevm_cnt_off, 32'd30, "window low count");
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_cmp_off, 32'h9);
    u_tevm_pulse_src.drive(1'b0, 10);
    i0 = irqs;
    wr(tevm_ctrl_off, 32'h3);
    u_tevm_pulse_src.drive(1'b1, 40);
    u_tevm_pulse_src.drive(1'b0, 10);
    chk("window matches", 32'(i0 + 4), 32'(irqs));
    // single edge pulse width, first capture one short of the second
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_ctrl_off, 32'h25);
    i0 = irqs;
    for (int k = 0; k < 2; k++)
    begin
      u_tevm_pulse_src.drive(1'b1, 50);
      mid(1'b0, 20);
      c1 = c0;
      c0 = rdat;
    end
    chk("single second capture", c1 + 32'h1, c0);
    chk("single width", 32'd50, c0);
    chk("single irqs", 32'(i0 + 2), 32'(irqs));
    rchk(tevm_cnt_off, 32'h1, "single rest count");
    rchk(tevm_caplo_off, 32'h32, "capture low byte");
    rchk(tevm_caphi_off, 32'h0, "capture high byte");
    // double edge: period minus high width is the low width
    wr(tevm_ctrl_off, 32'h0);
    wr(tevm_ctrl_off, 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      mid(1'b1, 30);
      c0 = rdat;
      mid(1'b0, 50);
      c1 = rdat;
    end
    chk("double period less width", 32'd50, c0 - c1);
    give_verdict;
  end
endmodule

`default_nettype wire
